// ===== design/ttr_cfg.svh
`ifndef TTR_CFG_SVH
`define TTR_CFG_SVH

// register addresses (7-bit spi address space)
`define TTR_ADDR_TEMP_CTRL   7'h4e
`define TTR_ADDR_TEMP_READ   7'h4f
`define TTR_ADDR_LNA         7'h58
`define TTR_ADDR_PA1         7'h5a
`define TTR_ADDR_PA2         7'h5c
`define TTR_ADDR_DAGC        7'h6f
`define TTR_ADDR_AFC         7'h71

// temperature control fields
`define TTR_CTRL_START_BIT   3
`define TTR_CTRL_RUN_BIT     2
`define TTR_CTRL_HIGH_ZERO   4'h0
`define TTR_CTRL_LOW_FILL    2'h1

// reset values and documented settings
`define TTR_RST_LNA          8'h1b
`define TTR_LNA_HIGH_SENS    8'h2d
`define TTR_RST_PA1          8'h55
`define TTR_PA1_BOOST        8'h5d
`define TTR_RST_PA2          8'h70
`define TTR_PA2_BOOST        8'h7c
`define TTR_RST_DAGC         8'h30
`define TTR_DAGC_NORMAL      8'h00
`define TTR_DAGC_LOW_BETA    8'h20
`define TTR_RST_AFC          8'h00
`define TTR_UNMAPPED_READ    8'h00

// offset step of the low index correction, in hz
`define TTR_AFC_STEP_HZ      17'h001e8
// reading = base minus die temperature; base is an uncalibrated origin
`define TTR_TEMP_BASE        8'h80

// timing
`define TTR_CLK_PERIOD_NS    32'h00000014
`define TTR_NS_PER_MS        32'h000f4240
`define TTR_POR_WAIT_MS      32'h0000000a
`define TTR_MAN_WAIT_MS      32'h00000005
`define TTR_CONV_CYCLES      32'h00000400

// spi framing
`define TTR_LAST_BIT         3'h7

`endif

// ===== design/ttr_pkg.sv
package ttr_pkg;

   typedef enum logic [2:0] {
      TTR_SPI_IDLE = 3'b001,
      TTR_SPI_ADDR = 3'b010,
      TTR_SPI_DATA = 3'b100
   } ttr_spi_e;

   typedef struct packed {
      logic [2:0] sck_sy;
      logic [2:0] mosi_sy;
      logic [2:0] nss_sy;
      logic [2:0] rst_sy;
      logic       sck_f;
      logic       mosi_f;
      logic       nss_f;
      logic       rst_f;
      ttr_spi_e   spi;
      logic [2:0] bit_cnt;
      logic [7:0] rx_sh;
      logic [7:0] tx_sh;
      logic [6:0] addr;
      logic       wnr;
      logic       miso;
      logic       miso_oe;
      logic [7:0] lna;
      logic [7:0] pa1;
      logic [7:0] pa2;
      logic [7:0] dagc;
      logic [7:0] afc;
      logic [7:0] reading;
      logic       busy;
      logic [15:0] conv_cnt;
      logic       ready;
      logic [19:0] wait_cnt;
      logic       ready_clock_output;
      logic       high_sens;
      logic [16:0] freq_off;
   } ttr_state_s;

endpackage : ttr_pkg

// ===== design/ttr_regs.sv
// Operation
// - writing one to start bit launches a conversion; start bit reads zero
// - running flag reads one during conversion, zero once done
// - reading is 8-bit read-only, falling one count per degree
// - sensitivity 0x1b selects normal, 0x2d selects high sensitivity
// - first high-power register 0x55 normally, host writes 0x5d for boost
// - second high-power register 0x70 normally, host writes 0x7c for boost
// - fading gain 0x00 normal; 0x20 with low index correction, else 0x30
// - offset equals register times 488 hz when correction enabled; resets zero
// - power-on reset at supply, manual reset through reset pin
// - clock output starts toggling once ready; activity means ready
`timescale 1ns/10ps
`include "ttr_cfg.svh"

module ttr_regs #(
   parameter int POR_WAIT_CYCLES = `TTR_POR_WAIT_MS * `TTR_NS_PER_MS / `TTR_CLK_PERIOD_NS,
   parameter int MAN_WAIT_CYCLES = `TTR_MAN_WAIT_MS * `TTR_NS_PER_MS / `TTR_CLK_PERIOD_NS,
   parameter int CONV_CYCLES     = `TTR_CONV_CYCLES
) (
   input  wire logic        core_clk_i,
   input  wire logic        sys_rst_i,
   input  wire logic        ce_i,
   input  wire logic        spi_sck_i,
   input  wire logic        spi_mosi_i,
   input  wire logic        spi_nss_i,
   output logic             spi_miso_o,
   output logic             spi_miso_oe_o,
   input  wire logic        reset_pin_i,
   input  wire logic        low_index_correction_enable_i,
   input  wire logic [7:0]  die_temp_i,
   output logic             ready_clock_output_o,
   output logic             dev_ready_o,
   output logic             rx_blocked_o,
   output logic [7:0]       rx_gain_select_o,
   output logic             rx_high_sens_o,
   output logic [7:0]       hipower_tune_a_o,
   output logic [7:0]       hipower_tune_b_o,
   output logic [7:0]       fading_gain_setting_o,
   output logic [16:0]      freq_offset_hz_o
);

   ttr_pkg::ttr_state_s st_r;
   ttr_pkg::ttr_state_s st_nxt;

   logic       sck_new;
   logic       mosi_new;
   logic       nss_new;
   logic       rst_new;
   logic       sck_rise;
   logic       sck_fall;
   logic [7:0] rx_next;
   logic       byte_done;
   logic       live;

   // a pin level counts only once the second and third stages agree
   assign sck_new   = (st_r.sck_sy[1] == st_r.sck_sy[2]) ? st_r.sck_sy[1] : st_r.sck_f;
   assign mosi_new  = (st_r.mosi_sy[1] == st_r.mosi_sy[2]) ? st_r.mosi_sy[1] : st_r.mosi_f;
   assign nss_new   = (st_r.nss_sy[1] == st_r.nss_sy[2]) ? st_r.nss_sy[1] : st_r.nss_f;
   assign rst_new   = (st_r.rst_sy[1] == st_r.rst_sy[2]) ? st_r.rst_sy[1] : st_r.rst_f;
   assign sck_rise  = sck_new & ~st_r.sck_f;
   assign sck_fall  = ~sck_new & st_r.sck_f;
   assign rx_next   = {st_r.rx_sh[6:0], mosi_new};
   assign byte_done = sck_rise && (st_r.bit_cnt == `TTR_LAST_BIT) && !nss_new;
   assign live      = st_r.ready && !rst_new;

   function automatic logic [7:0] rd_mux(input logic [6:0] a, input ttr_pkg::ttr_state_s s);
      logic [7:0] v;
      v = `TTR_UNMAPPED_READ;
      if (a == `TTR_ADDR_TEMP_CTRL) begin
         v = {`TTR_CTRL_HIGH_ZERO, 1'b0, s.busy, `TTR_CTRL_LOW_FILL};
      end else if (a == `TTR_ADDR_TEMP_READ) begin
         v = s.reading;
      end else if (a == `TTR_ADDR_LNA) begin
         v = s.lna;
      end else if (a == `TTR_ADDR_PA1) begin
         v = s.pa1;
      end else if (a == `TTR_ADDR_PA2) begin
         v = s.pa2;
      end else if (a == `TTR_ADDR_DAGC) begin
         v = s.dagc;
      end else if (a == `TTR_ADDR_AFC) begin
         v = s.afc;
      end
      return v;
   endfunction : rd_mux

   always_comb begin
      st_nxt = st_r;
      // first stage feeds only the second
      st_nxt.sck_sy  = {st_r.sck_sy[1:0], spi_sck_i};
      st_nxt.mosi_sy = {st_r.mosi_sy[1:0], spi_mosi_i};
      st_nxt.nss_sy  = {st_r.nss_sy[1:0], spi_nss_i};
      st_nxt.rst_sy  = {st_r.rst_sy[1:0], reset_pin_i};
      st_nxt.sck_f   = sck_new;
      st_nxt.mosi_f  = mosi_new;
      st_nxt.nss_f   = nss_new;
      st_nxt.rst_f   = rst_new;
      st_nxt.high_sens = (st_r.lna == `TTR_LNA_HIGH_SENS);
      st_nxt.freq_off  = low_index_correction_enable_i ?
                         17'(st_r.afc * `TTR_AFC_STEP_HZ) : 17'h00000;
      if (rst_new) begin
         // manual reset: settings and control back to defaults, reading kept, held while pin is high
         st_nxt.lna      = `TTR_RST_LNA;
         st_nxt.pa1      = `TTR_RST_PA1;
         st_nxt.pa2      = `TTR_RST_PA2;
         st_nxt.dagc     = `TTR_RST_DAGC;
         st_nxt.afc      = `TTR_RST_AFC;
         st_nxt.busy     = 1'b0;
         st_nxt.conv_cnt = 16'h0000;
         st_nxt.ready    = 1'b0;
         st_nxt.wait_cnt = 20'(MAN_WAIT_CYCLES);
         st_nxt.ready_clock_output   = 1'b0;
         st_nxt.spi      = ttr_pkg::TTR_SPI_IDLE;
         st_nxt.miso_oe  = 1'b0;
         st_nxt.miso     = 1'b0;
      end else if (!st_r.ready) begin
         // spi is deaf until ready; the host is told so by the quiet clock output
         if (st_r.wait_cnt != 20'h00000) begin
            st_nxt.wait_cnt = st_r.wait_cnt - 20'h00001;
         end else begin
            st_nxt.ready = 1'b1;
         end
      end else begin
         st_nxt.ready_clock_output = ~st_r.ready_clock_output;
         if (st_r.busy) begin
            if (st_r.conv_cnt == 16'h0000) begin
               st_nxt.busy    = 1'b0;
               st_nxt.reading = `TTR_TEMP_BASE - die_temp_i;
            end else begin
               st_nxt.conv_cnt = st_r.conv_cnt - 16'h0001;
            end
         end
         if (nss_new) begin
            st_nxt.spi     = ttr_pkg::TTR_SPI_IDLE;
            st_nxt.miso_oe = 1'b0;
         end else begin
            case (st_r.spi)
               ttr_pkg::TTR_SPI_IDLE: begin
                  st_nxt.spi     = ttr_pkg::TTR_SPI_ADDR;
                  st_nxt.bit_cnt = 3'h0;
                  st_nxt.tx_sh   = 8'h00;
                  st_nxt.miso    = 1'b0;
                  st_nxt.miso_oe = 1'b1;
               end
               ttr_pkg::TTR_SPI_ADDR: begin
                  if (byte_done) begin
                     st_nxt.wnr   = rx_next[7];
                     st_nxt.addr  = rx_next[6:0];
                     st_nxt.tx_sh = rd_mux(rx_next[6:0], st_r);
                     st_nxt.spi   = ttr_pkg::TTR_SPI_DATA;
                  end
               end
               ttr_pkg::TTR_SPI_DATA: begin
                  if (byte_done) begin
                     // burst: address advances after every data byte
                     st_nxt.addr  = st_r.addr + 7'h01;
                     st_nxt.tx_sh = rd_mux(st_r.addr + 7'h01, st_r);
                     if (st_r.wnr) begin
                        if (st_r.addr == `TTR_ADDR_TEMP_CTRL) begin
                           // start is a strobe, never stored; retrigger while busy is ignored
                           if (rx_next[`TTR_CTRL_START_BIT] && !st_r.busy) begin
                              st_nxt.busy     = 1'b1;
                              st_nxt.conv_cnt = 16'(CONV_CYCLES - 1);
                           end
                        end else if (st_r.addr == `TTR_ADDR_LNA) begin
                           st_nxt.lna = rx_next;
                        end else if (st_r.addr == `TTR_ADDR_PA1) begin
                           st_nxt.pa1 = rx_next;
                        end else if (st_r.addr == `TTR_ADDR_PA2) begin
                           st_nxt.pa2 = rx_next;
                        end else if (st_r.addr == `TTR_ADDR_DAGC) begin
                           st_nxt.dagc = rx_next;
                        end else if (st_r.addr == `TTR_ADDR_AFC) begin
                           st_nxt.afc = rx_next;
                        end
                     end
                  end
               end
               default: begin
                  st_nxt.spi = ttr_pkg::TTR_SPI_IDLE;
               end
            endcase
            if (sck_rise) begin
               st_nxt.rx_sh   = rx_next;
               st_nxt.bit_cnt = st_r.bit_cnt + 3'h1;
            end
            if (sck_fall && (st_r.spi != ttr_pkg::TTR_SPI_IDLE)) begin
               st_nxt.miso  = st_r.tx_sh[7];
               st_nxt.tx_sh = {st_r.tx_sh[6:0], 1'b0};
            end
         end
      end
   end

   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         // power-on reset
         st_r          <= '0;
         st_r.nss_sy   <= 3'h7;
         st_r.nss_f    <= 1'b1;
         st_r.spi      <= ttr_pkg::TTR_SPI_IDLE;
         st_r.lna      <= `TTR_RST_LNA;
         st_r.pa1      <= `TTR_RST_PA1;
         st_r.pa2      <= `TTR_RST_PA2;
         st_r.dagc     <= `TTR_RST_DAGC;
         st_r.afc      <= `TTR_RST_AFC;
         st_r.wait_cnt <= 20'(POR_WAIT_CYCLES);
      end else if (ce_i) begin
         st_r <= st_nxt;
      end
   end

   assign spi_miso_o            = st_r.miso;
   assign spi_miso_oe_o         = st_r.miso_oe;
   assign ready_clock_output_o  = st_r.ready_clock_output;
   assign dev_ready_o           = st_r.ready;
   assign rx_blocked_o          = st_r.busy;
   assign rx_gain_select_o      = st_r.lna;
   assign rx_high_sens_o        = st_r.high_sens;
   assign hipower_tune_a_o      = st_r.pa1;
   assign hipower_tune_b_o      = st_r.pa2;
   assign fading_gain_setting_o = st_r.dagc;
   assign freq_offset_hz_o      = st_r.freq_off;

   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (sys_rst_i);

   sequence s_start_write;
      ce_i && live && byte_done && (st_r.spi == ttr_pkg::TTR_SPI_DATA) && st_r.wnr &&
      (st_r.addr == `TTR_ADDR_TEMP_CTRL) && rx_next[`TTR_CTRL_START_BIT] && !st_r.busy;
   endsequence
   sequence s_conv_last;
      ce_i && live && st_r.busy && (st_r.conv_cnt == 16'h0000);
   endsequence
   sequence s_manual_reset;
      ce_i && rst_new;
   endsequence

   a_start_launch: assert property (s_start_write |=> st_r.busy &&
      st_r.conv_cnt == 16'(CONV_CYCLES - 1)) else $error("start write did not launch");
   a_ctrl_readback: assert property (ce_i && live && byte_done &&
      st_r.spi == ttr_pkg::TTR_SPI_ADDR && rx_next[6:0] == `TTR_ADDR_TEMP_CTRL |=>
      st_r.tx_sh[`TTR_CTRL_RUN_BIT] == $past(st_r.busy) && !st_r.tx_sh[`TTR_CTRL_START_BIT])
      else $error("control readback wrong");
   a_conv_end: assert property (s_conv_last |=> !st_r.busy)
      else $error("conversion overran");
   a_reading_update: assert property (s_conv_last |=>
      st_r.reading == `TTR_TEMP_BASE - $past(die_temp_i))
      else $error("reading not updated");
   a_sens_select: assert property (ce_i |=>
      rx_high_sens_o == ($past(st_r.lna) == `TTR_LNA_HIGH_SENS))
      else $error("sensitivity select wrong");
   a_reset_values: assert property (s_manual_reset |=>
      hipower_tune_a_o == `TTR_RST_PA1 &&
      hipower_tune_b_o == `TTR_RST_PA2 && fading_gain_setting_o == `TTR_RST_DAGC &&
      st_r.afc == `TTR_RST_AFC && !dev_ready_o)
      else $error("manual reset values wrong");
   a_freq_offset: assert property (ce_i |=> freq_offset_hz_o ==
      ($past(low_index_correction_enable_i) ? 17'($past(st_r.afc) * `TTR_AFC_STEP_HZ) : 17'h0))
      else $error("frequency offset wrong");
   a_clk_quiet: assert property (!dev_ready_o |-> !ready_clock_output_o)
      else $error("clock output active before ready");
   a_clk_toggle: assert property (ce_i && live |=>
      ready_clock_output_o != $past(ready_clock_output_o))
      else $error("clock output not toggling");

endmodule : ttr_regs

// ===== tb/ttr_host.sv
`timescale 1ns/10ps
module ttr_host (
   input  wire logic clk_i,
   input  wire logic miso_i,
   input  wire logic miso_oe_i,
   input  wire logic ready_i,
   output logic      sck_o,
   output logic      mosi_o,
   output logic      nss_o,
   output logic      rst_pin_o
);
   logic last_r;
   logic line;
   // a released miso shows the inverse of its last level, never a lucky match
   assign line = miso_oe_i ? miso_i : ~last_r;
   initial begin
      sck_o = 1'b0;
      mosi_o = 1'b0;
      nss_o = 1'b1;
      rst_pin_o = 1'b0;
      last_r = 1'b0;
   end
   always @(posedge clk_i) if (miso_oe_i) last_r <= miso_i;
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask : tick
   task automatic await_ready(output bit ok);
      ok = 1'b0;
      for (int i = 0; i < 2000 && !ok; i++) begin
         @(posedge clk_i);
         ok = (ready_i === 1'b1);
      end
      tick(4);
   endtask : await_ready
   // six core clocks per half period keeps clear of the pin filters
   task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd, output logic [7:0] rd);
      logic [15:0] sh;
      sh = {cmd, wd};
      rd = 8'h00;
      nss_o <= 1'b0;
      tick(6);
      for (int i = 15; i >= 0; i--) begin
         mosi_o <= sh[i];
         tick(6);
         if (i < 8) rd[i] = line;
         sck_o <= 1'b1;
         tick(6);
         sck_o <= 1'b0;
      end
      tick(6);
      nss_o <= 1'b1;
      mosi_o <= ~mosi_o;
      tick(8);
   endtask : xfer
   task automatic man_reset(input int n);
      rst_pin_o <= 1'b1;
      tick(n);
      rst_pin_o <= 1'b0;
   endtask : man_reset
endmodule : ttr_host

// ===== tb/ttr_regs_test.sv
`timescale 1ns/10ps
`include "ttr_cfg.svh"
module ttr_regs_test;
   localparam int CONV = 400;
   logic        clk, rst, ce, sck, mosi, nss, miso, moe, rpin, lbe, rclk, rdy, blk, hs, p;
   logic [7:0]  die, gain, pa_a, pa_b, fgs, rd;
   logic [16:0] foff;
   int          failures, compares, run_cnt, mdl[int];
   bit          ok;
   logic [6:0]  wa[4] = '{`TTR_ADDR_LNA, `TTR_ADDR_PA1, `TTR_ADDR_PA2, `TTR_ADDR_DAGC};
   logic [7:0]  wv[4] = '{`TTR_LNA_HIGH_SENS, `TTR_PA1_BOOST, `TTR_PA2_BOOST, `TTR_DAGC_LOW_BETA};
   ttr_regs #(.POR_WAIT_CYCLES(20), .MAN_WAIT_CYCLES(10), .CONV_CYCLES(CONV)) ttr_regs_inst (
      .core_clk_i(clk), .sys_rst_i(rst), .ce_i(ce), .spi_sck_i(sck), .spi_mosi_i(mosi),
      .spi_nss_i(nss), .spi_miso_o(miso), .spi_miso_oe_o(moe), .reset_pin_i(rpin),
      .low_index_correction_enable_i(lbe), .die_temp_i(die), .ready_clock_output_o(rclk),
      .dev_ready_o(rdy), .rx_blocked_o(blk), .rx_gain_select_o(gain), .rx_high_sens_o(hs),
      .hipower_tune_a_o(pa_a), .hipower_tune_b_o(pa_b), .fading_gain_setting_o(fgs),
      .freq_offset_hz_o(foff));
   ttr_host ttr_host_inst (.clk_i(clk), .miso_i(miso), .miso_oe_i(moe), .ready_i(rdy),
      .sck_o(sck), .mosi_o(mosi), .nss_o(nss), .rst_pin_o(rpin));
   initial clk = 1'b0;
   always #10 clk = ~clk;
   always @(posedge clk) if (blk === 1'b1) run_cnt <= run_cnt + 1;
   task automatic end_sim;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : end_sim
   task automatic chk_val(input string nm, input logic [16:0] e, input logic [16:0] g);
      compares++;
      if (g !== e) begin
         failures++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : chk_val
   task automatic chk_bit(input string nm, input logic e, input logic g);
      compares++;
      if (g !== e) begin
         failures++;
         $display("mismatch %s expected %b seen %b", nm, e, g);
      end
   endtask : chk_bit
   task automatic step;
      @(posedge clk);
      #1;
   endtask : step
   // reading survives a manual reset, so it is passed in rather than cleared
   task automatic mreset(input int reading);
      mdl.delete();
      mdl[`TTR_ADDR_TEMP_CTRL] = 8'h01;
      mdl[`TTR_ADDR_TEMP_READ] = reading;
      mdl[`TTR_ADDR_LNA] = `TTR_RST_LNA;
      mdl[`TTR_ADDR_PA1] = `TTR_RST_PA1;
      mdl[`TTR_ADDR_PA2] = `TTR_RST_PA2;
      mdl[`TTR_ADDR_DAGC] = `TTR_RST_DAGC;
      mdl[`TTR_ADDR_AFC] = `TTR_RST_AFC;
   endtask : mreset
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      ttr_host_inst.xfer({1'b1, a}, d, rd);
      if (mdl.exists(a) && a != `TTR_ADDR_TEMP_READ && a != `TTR_ADDR_TEMP_CTRL) mdl[a] = d;
   endtask : wr
   task automatic rdc(input logic [6:0] a);
      ttr_host_inst.xfer({1'b0, a}, 8'h00, rd);
      chk_val("spi read", mdl.exists(a) ? mdl[a] : 0, {9'h000, rd});
   endtask : rdc
   task automatic outs;
      chk_val("gain", mdl[`TTR_ADDR_LNA], {9'h000, gain});
      chk_bit("high sens", mdl[`TTR_ADDR_LNA] == `TTR_LNA_HIGH_SENS, hs);
      chk_val("tune a", mdl[`TTR_ADDR_PA1], {9'h000, pa_a});
      chk_val("tune b", mdl[`TTR_ADDR_PA2], {9'h000, pa_b});
      chk_val("fading", mdl[`TTR_ADDR_DAGC], {9'h000, fgs});
      chk_val("offset", lbe ? mdl[`TTR_ADDR_AFC] * 488 : 0, foff);
   endtask : outs
   initial begin
      {ce, rst, lbe, die, failures, compares, run_cnt} = {1'b1, 1'b1, 1'b0, 8'h00, 96'h0};
      void'($urandom(32'h2eed));
      mreset(0);
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      step;
      chk_bit("ready early", 1'b0, rdy);
      chk_bit("clock out idle", 1'b0, rclk);
      ttr_host_inst.await_ready(ok);
      chk_bit("ready", 1'b1, ok);
      // sample off the edge so the launching edge does not race the read
      step;
      p = rclk;
      step;
      chk_bit("clock out runs", ~p, rclk);
      @(posedge clk);
      ce <= 1'b0;
      step;
      p = rclk;
      repeat (4) step;
      chk_bit("clock out frozen", p, rclk);
      @(posedge clk);
      ce <= 1'b1;
      outs;
      foreach (mdl[a]) rdc(7'(a));
      chk_bit("miso released", 1'b0, moe);
      $display("test power-on done");
      foreach (wa[k]) begin
         wr(wa[k], wv[k]);
         rdc(wa[k]);
         outs;
      end
      wr(`TTR_ADDR_AFC, 8'($urandom));
      for (int k = 0; k < 2; k++) begin
         @(posedge clk);
         lbe <= ~lbe;
         step;
         step;
         outs;
      end
      wr(`TTR_ADDR_PA1, `TTR_RST_PA1);
      wr(`TTR_ADDR_PA2, `TTR_RST_PA2);
      wr(`TTR_ADDR_DAGC, `TTR_DAGC_NORMAL);
      outs;
      $display("test settings done");
      die <= 8'($urandom);
      run_cnt = 0;
      wr(`TTR_ADDR_TEMP_CTRL, 8'h08);
      chk_bit("running", 1'b1, blk);
      mdl[`TTR_ADDR_TEMP_CTRL] = 8'h05;
      rdc(`TTR_ADDR_TEMP_CTRL);
      for (int i = 0; i < 1000 && blk !== 1'b0; i++) step;
      chk_val("duration", CONV, 17'(run_cnt));
      mdl[`TTR_ADDR_TEMP_CTRL] = 8'h01;
      mdl[`TTR_ADDR_TEMP_READ] = 8'(8'h80 - die);
      rdc(`TTR_ADDR_TEMP_CTRL);
      wr(`TTR_ADDR_TEMP_READ, ~die);
      rdc(`TTR_ADDR_TEMP_READ);
      wr(7'h60, 8'ha5);
      rdc(7'h60);
      $display("test temperature done");
      wr(`TTR_ADDR_PA1, `TTR_PA1_BOOST);
      ttr_host_inst.man_reset(20);
      step;
      chk_bit("ready in reset", 1'b0, rdy);
      chk_bit("clock out held", 1'b0, rclk);
      mreset(mdl[`TTR_ADDR_TEMP_READ]);
      ttr_host_inst.await_ready(ok);
      chk_bit("ready again", 1'b1, rdy);
      outs;
      rdc(`TTR_ADDR_PA1);
      rdc(`TTR_ADDR_TEMP_READ);
      $display("test manual reset done");
      end_sim;
   end
   initial begin
      repeat (30000) @(posedge clk);
      failures++;
      $display("test timeout");
      end_sim;
   end
endmodule : ttr_regs_test
